// *** logic/wdt_pkg.sv ***
// constants shared by the watchdog block: map, fields, reset values, timing
// Operation
// - counter write needs filter bits all zero
// - accepted write reloads count from data byte
// - read gives live count plus negative flag
// - decrement by one per timebase tick
// - below zero wraps as 9-bit two's complement
// - mode zero raises NMI at count zero
// - mode zero resets at minus sixteen, reloads
// - mode one resets at zero or below
// - mode zero halts while freeze flag set
// - mode one ignores software freeze
// - mode bit set-only, cleared by resets
// - debug halt always stops the countdown
package wdt_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    // timebase period in microseconds (10.24 ms)
    localparam int unsigned TICK_PERIOD_US = 10240;
    // clock cycles per timebase tick, rounded down to whole cycles
    localparam int unsigned TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // register map: printed offsets are register indexes, byte = 4 * index
    // ------------------------------------------------------------------
    localparam logic [31:0] PRINT_BASE = 32'h5000_3100;
    localparam logic [31:0] PRINT_COUNTER = 32'h5000_3100;
    localparam logic [31:0] PRINT_CONTROL = 32'h5000_3102;
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER = ADDR_W'(4 * (PRINT_COUNTER - PRINT_BASE));
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'(4 * (PRINT_CONTROL - PRINT_BASE));
    // freeze set and freeze clear strobes
    localparam logic [ADDR_W-1:0] ADDR_FREEZE_SET = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_FREEZE_CLR = 8'h14;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned FILTER_HI = 15;
    localparam int unsigned FILTER_LO = 9;
    localparam int unsigned NEG_BIT = 8;
    localparam int unsigned VAL_HI = 7;
    localparam int unsigned CTRL_MODE_BIT = 0;
    localparam int unsigned CTRL_SPARE_BIT = 1;
    localparam int unsigned FREEZE_BIT = 0;

    // ------------------------------------------------------------------
    // count values and reset values
    // ------------------------------------------------------------------
    localparam int unsigned COUNT_W = 9;
    localparam logic [8:0] COUNT_RESET = 9'h0ff;
    localparam logic [8:0] COUNT_RELOAD = 9'h0ff;
    localparam logic [8:0] COUNT_ZERO = 9'h000;
    localparam logic [8:0] COUNT_FIRE_NMI_MODE = 9'h1f0;
    localparam logic [1:0] CTRL_RESET = 2'h0;
endpackage

// *** logic/wdt_prescaler.sv ***
// timebase prescaler: one tick pulse per programmed number of clocks
`timescale 1ns/1ps
module wdt_prescaler #(
    parameter int unsigned P_CYCLES = wdt_pkg::TICK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_restart,
    input wire logic i_run,
    output logic o_tick
);
    localparam int unsigned CW = (P_CYCLES > 2) ? $clog2(P_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(P_CYCLES - 1);

    // refuse periods the divider cannot make
    if (P_CYCLES < 2)
    begin : g_bad_period
        $error("prescaler period must be at least two cycles");
    end

    logic [CW-1:0] div; // cycles into the current period

    // ------------------------------------------------------------------
    // divider: holds while stopped, restarts on reload
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_rst || i_restart)
        begin
            div <= '0;
            o_tick <= 1'b0;
        end
        else if (i_run)
        begin
            // last cycle of the period emits the pulse
            o_tick <= (div == LAST);
            div <= (div == LAST) ? '0 : div + CW'(1);
        end
        else
        begin
            o_tick <= 1'b0;
        end
    end

    // ticks of a running divider fall on a period boundary, never two in a row
    tick_space_a: assert property (@(posedge i_mclk) disable iff (i_rst || i_restart)
        o_tick |-> (div == '0) && !$past(o_tick))
        else $error("tick not at period boundary");
endmodule

// *** logic/wdt_ahb_slave.sv ***
// ahb-lite slave front end: zero wait states, registered read data
`timescale 1ns/1ps
module wdt_ahb_slave #(
    parameter int unsigned AW = wdt_pkg::ADDR_W
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [AW-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] i_rd_data,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_wr_en,
    output logic [AW-1:0] o_wr_addr,
    output logic [31:0] o_wr_data,
    output logic o_rd_en,
    output logic [AW-1:0] o_rd_addr
);
    logic take; // address phase accepted this edge
    logic ph_wr; // write data phase pending
    logic [AW-1:0] ph_addr; // address held for the data phase

    // only whole-word single transfers are used; only a size code of 7 is refused
    assign take = i_hsel && i_hready && i_htrans[1] && (i_hsize != 3'h7);
    assign o_rd_en = take && !i_hwrite;
    assign o_rd_addr = i_haddr;
    assign o_wr_en = ph_wr;
    assign o_wr_addr = ph_addr;
    assign o_wr_data = i_hwdata;

    // ------------------------------------------------------------------
    // address phase capture and response flops
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            ph_wr <= 1'b0;
            ph_addr <= '0;
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else
        begin
            ph_wr <= take && i_hwrite;
            ph_addr <= i_haddr;
            // read data sampled at the address phase, shown in data phase
            o_hrdata <= o_rd_en ? i_rd_data : 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end
endmodule

// *** logic/wdt_top.sv ***
// watchdog timer with nmi and system reset, ahb-lite register access
`timescale 1ns/1ps
module wdt_top #(
    parameter int unsigned P_TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_sw_rst,
    input wire logic i_dbg_halt,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_nmi,
    output logic o_wdt_reset
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam int unsigned AW = wdt_pkg::ADDR_W;

    // refuse a timebase too short to serve
    if (P_TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("timebase must be at least two cycles");
    end

    logic wr_en; // write data phase strobe
    logic [AW-1:0] wr_addr; // write address
    logic [31:0] wr_data; // write data
    logic rd_en; // read address phase strobe
    logic [AW-1:0] rd_addr; // read address
    logic [31:0] rd_data; // read mux output
    logic tick; // timebase pulse

    logic [8:0] count; // signed live counter
    logic nmi_mode_off; // response select: 1 = direct reset
    logic ctrl_spare; // spare read/write control bit
    logic freeze_flag; // software freeze request

    logic wr_counter; // write hits counter register
    logic wr_accept; // write passes the filter
    logic wr_control; // write hits control register
    logic wr_frz_set; // write to freeze set strobe
    logic wr_frz_clr; // write to freeze clear strobe
    logic frozen; // countdown stopped this cycle
    logic fire; // watchdog reset condition
    logic blk_rst; // reset of the block except the bus front end

    // ------------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------------
    wdt_ahb_slave #(
        .AW(AW)
    ) u_bus (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr[AW-1:0]),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hsize(i_hsize),
        .i_hwdata(i_hwdata),
        .i_hready(i_hready),
        .i_rd_data(rd_data),
        .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp),
        .o_wr_en(wr_en),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_rd_en(rd_en),
        .o_rd_addr(rd_addr)
    );

    // ------------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------------
    wdt_prescaler #(
        .P_CYCLES(P_TICK_CYCLES)
    ) u_tick (
        .i_mclk(i_mclk),
        .i_rst(blk_rst),
        .i_restart(wr_accept || fire),
        .i_run(!frozen),
        .o_tick(tick)
    );

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    assign blk_rst = i_rst || i_sw_rst;

    // address decode of the write data phase
    always_comb
    begin
        wr_counter = 1'b0;
        wr_control = 1'b0;
        wr_frz_set = 1'b0;
        wr_frz_clr = 1'b0;
        if (wr_addr == wdt_pkg::ADDR_COUNTER)
        begin
            wr_counter = wr_en;
        end
        else if (wr_addr == wdt_pkg::ADDR_CONTROL)
        begin
            wr_control = wr_en;
        end
        else if (wr_addr == wdt_pkg::ADDR_FREEZE_SET)
        begin
            wr_frz_set = wr_en && wr_data[wdt_pkg::FREEZE_BIT];
        end
        else if (wr_addr == wdt_pkg::ADDR_FREEZE_CLR)
        begin
            wr_frz_clr = wr_en && wr_data[wdt_pkg::FREEZE_BIT];
        end
    end

    // filter: upper seven bits must all be zero
    assign wr_accept = wr_counter && (wr_data[wdt_pkg::FILTER_HI:wdt_pkg::FILTER_LO] == 7'h00);

    // ------------------------------------------------------------------
    // stop and fire conditions
    // ------------------------------------------------------------------
    // debug halt always stops; freeze flag only in nmi mode
    assign frozen = i_dbg_halt || (freeze_flag && !nmi_mode_off);

    // reset at minus sixteen in nmi mode, at zero or below otherwise
    always_comb
    begin
        if (nmi_mode_off)
        begin
            fire = (count == wdt_pkg::COUNT_ZERO) || count[wdt_pkg::NEG_BIT];
        end
        else
        begin
            fire = (count == wdt_pkg::COUNT_FIRE_NMI_MODE);
        end
    end

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // watchdog reset outranks a write, a write outranks a tick
    always_ff @(posedge i_mclk)
    begin
        if (blk_rst)
        begin
            count <= wdt_pkg::COUNT_RESET;
        end
        else if (fire)
        begin
            count <= wdt_pkg::COUNT_RELOAD;
        end
        else if (wr_accept)
        begin
            count <= {1'b0, wr_data[wdt_pkg::VAL_HI:0]};
        end
        else if (tick && !frozen)
        begin
            // 9-bit subtraction wraps zero to all ones
            count <= count - 9'h001;
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    // mode bit: software can only set it; resets clear it
    always_ff @(posedge i_mclk)
    begin
        if (blk_rst || fire)
        begin
            nmi_mode_off <= wdt_pkg::CTRL_RESET[wdt_pkg::CTRL_MODE_BIT];
        end
        else if (wr_control && wr_data[wdt_pkg::CTRL_MODE_BIT])
        begin
            nmi_mode_off <= 1'b1;
        end
    end

    // spare bit: plain storage
    always_ff @(posedge i_mclk)
    begin
        if (blk_rst)
        begin
            ctrl_spare <= wdt_pkg::CTRL_RESET[wdt_pkg::CTRL_SPARE_BIT];
        end
        else if (wr_control)
        begin
            ctrl_spare <= wr_data[wdt_pkg::CTRL_SPARE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // freeze flag
    // ------------------------------------------------------------------
    // set strobe wins over a clear strobe in the same cycle
    always_ff @(posedge i_mclk)
    begin
        if (blk_rst || fire)
        begin
            freeze_flag <= 1'b0;
        end
        else if (wr_frz_set)
        begin
            freeze_flag <= 1'b1;
        end
        else if (wr_frz_clr)
        begin
            freeze_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // responses to the processor
    // ------------------------------------------------------------------
    // nmi level while at zero in nmi mode; reset pulse on fire
    always_ff @(posedge i_mclk)
    begin
        if (blk_rst)
        begin
            o_nmi <= 1'b0;
            o_wdt_reset <= 1'b0;
        end
        else
        begin
            o_nmi <= !nmi_mode_off && (count == wdt_pkg::COUNT_ZERO);
            o_wdt_reset <= fire;
        end
    end

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    // unmapped addresses read as zero
    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (!rd_en)
        begin
            rd_data = 32'h0000_0000;
        end
        else if (rd_addr == wdt_pkg::ADDR_COUNTER)
        begin
            rd_data[8:0] = count;
        end
        else if (rd_addr == wdt_pkg::ADDR_CONTROL)
        begin
            rd_data[wdt_pkg::CTRL_MODE_BIT] = nmi_mode_off;
            rd_data[wdt_pkg::CTRL_SPARE_BIT] = ctrl_spare;
        end
        else if ((rd_addr == wdt_pkg::ADDR_FREEZE_SET) || (rd_addr == wdt_pkg::ADDR_FREEZE_CLR))
        begin
            rd_data[wdt_pkg::FREEZE_BIT] = freeze_flag;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // a filtered-out write leaves the counter alone
    filter_block_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (wr_counter && !wr_accept && !fire && !(tick && !frozen)) |=> $stable(count))
        else $error("rejected write changed the counter");

    // an accepted write loads the data byte
    write_load_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (wr_accept && !fire) |=> (count == {1'b0, $past(wr_data[7:0])}))
        else $error("accepted write did not load the counter");

    // counter reads show value and sign
    read_value_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (rd_en && (rd_addr == wdt_pkg::ADDR_COUNTER)) |=>
            (o_hrdata[8:0] == $past(count)) && (o_hrdata[31:9] == 23'h00_0000))
        else $error("counter read data wrong");

    // one step down per running tick
    tick_step_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (tick && !frozen && !fire && !wr_accept) |=> (count == $past(count) - 9'h001))
        else $error("counter did not step by one");

    // zero steps to all ones
    wrap_ones_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (tick && !frozen && !fire && !wr_accept && (count == 9'h000)) |=> (count == 9'h1ff))
        else $error("counter did not wrap to all ones");

    // nmi raised at zero in nmi mode and held there
    nmi_raise_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (!nmi_mode_off && (count == 9'h000)) |=> o_nmi)
        else $error("nmi missing at zero");

    // reset at minus sixteen in nmi mode, then full reload
    neg_reset_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (!nmi_mode_off && (count == 9'h1f0)) |=> (o_wdt_reset && (count == 9'h0ff)) ##1 !o_wdt_reset)
        else $error("reset at minus sixteen wrong");

    // direct mode resets at zero or below, never nmi
    direct_reset_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (nmi_mode_off && ((count == 9'h000) || count[8])) |=> (o_wdt_reset && !o_nmi && (count == 9'h0ff)))
        else $error("direct mode reset wrong");

    // freeze flag holds the count in nmi mode
    freeze_hold_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (freeze_flag && !nmi_mode_off && !wr_accept && !fire) |=> $stable(count))
        else $error("frozen counter moved");

    // direct mode keeps counting through software freeze
    freeze_ignore_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (nmi_mode_off && freeze_flag && !i_dbg_halt && tick && !fire && !wr_accept)
            |=> (count == $past(count) - 9'h001))
        else $error("direct mode obeyed software freeze");

    // mode bit never cleared by software
    mode_sticky_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (nmi_mode_off && !fire) |=> nmi_mode_off)
        else $error("mode bit cleared without reset");

    // debug halt stops the countdown in either mode
    debug_hold_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (i_dbg_halt && !wr_accept && !fire) |=> $stable(count))
        else $error("counter moved in debug halt");

    // nmi stays low away from zero and in direct mode
    nmi_quiet_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        !(!nmi_mode_off && (count == 9'h000)) |=> !o_nmi)
        else $error("nmi raised away from zero");

    // without a tick, an accepted write or a reset the count holds
    count_idle_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        (!tick && !wr_accept && !fire) |=> $stable(count))
        else $error("counter moved without a tick");

    // no reset request without its condition
    reset_cause_a: assert property (@(posedge i_mclk) disable iff (blk_rst)
        !fire |=> !o_wdt_reset)
        else $error("reset pulse without cause");
endmodule

// *** verif/wdt_top_bench.sv ***
// self-checking testbench for the watchdog block over ahb-lite
`timescale 1ns/1ps
`define CHECK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module wdt_top_bench;
    // ------------------------------------------------------------------
    // stimulus signals and counters
    // ------------------------------------------------------------------
    localparam int unsigned P = 16; // shortened timebase in clocks
    localparam logic [31:0] A_CNT = {24'h00_0000, wdt_pkg::ADDR_COUNTER};
    localparam logic [31:0] A_CTL = {24'h00_0000, wdt_pkg::ADDR_CONTROL};
    localparam logic [31:0] A_FSET = {24'h00_0000, wdt_pkg::ADDR_FREEZE_SET};
    localparam logic [31:0] A_FCLR = {24'h00_0000, wdt_pkg::ADDR_FREEZE_CLR};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic sw_rst = 1'b0;
    logic dbg = 1'b1; // debug halt, high from the start and dropped while the count is to run
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic nmi;
    logic wdt_reset;
    logic [31:0] rd;
    int n;
    int failures = 0;
    int n_compared = 0;

    // clock: 20 MHz
    always #25 mclk = ~mclk;

    wdt_top #(.P_TICK_CYCLES(P)) dut (
        .i_mclk(mclk), .i_rst(rst), .i_sw_rst(sw_rst), .i_dbg_halt(dbg), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .o_nmi(nmi), .o_wdt_reset(wdt_reset)
    );

    // ------------------------------------------------------------------
    // bus and wait helpers
    // ------------------------------------------------------------------
    // one single word transfer; called just after a rising edge, ends on one
    // waits as long as the slave needs; only the bench timeout ends a hang
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do
        begin
            @(posedge mclk);
        end
        while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do
        begin
            @(posedge mclk);
        end
        while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    // read one register and compare it
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0000_0000);
        `CHECK(rd, exp)
        `CHECK(hresp, 1'b0)
    endtask

    // count edges until nmi (sel 0) or reset (sel 1) shows the level
    task automatic wait_for(input bit sel, input logic lvl);
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while ((sel ? wdt_reset : nmi) !== lvl);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // reset values, unmapped place, write filter, reload, spare bit, debug halt
    task automatic t_regs();
        rchk(A_CNT, 32'h0000_00ff);
        rchk(A_CTL, 32'h0000_0000);
        rchk(32'h0000_0004, 32'h0000_0000);
        wr(32'h0000_0004, 32'h0000_0011);
        wr(A_CNT, 32'h0000_fe33);
        rchk(A_CNT, 32'h0000_00ff);
        wr(A_CNT, 32'h0000_0233);
        rchk(A_CNT, 32'h0000_00ff);
        wr(A_CNT, 32'h0000_8033);
        rchk(A_CNT, 32'h0000_00ff);
        wr(A_CNT, 32'h0000_0133);
        rchk(A_CNT, 32'h0000_0033);
        wr(A_CNT, 32'hffff_0044);
        repeat (4 * P) @(posedge mclk);
        rchk(A_CNT, 32'h0000_0044);
        wr(A_CTL, 32'h0000_0002);
        rchk(A_CTL, 32'h0000_0002);
        wr(A_CTL, 32'h0000_0000);
        rchk(A_CTL, 32'h0000_0000);
    endtask

    // mode zero: nmi at zero, reset sixteen ticks later, reload
    task automatic t_nmi_reset();
        wr(A_CNT, 32'h0000_0002);
        dbg <= 1'b0;
        wait_for(1'b0, 1'b1);
        `CHECK((n > P) && (n <= 2 * P + 3), 1'b1)
        wait_for(1'b0, 1'b0);
        `CHECK(n, P)
        wait_for(1'b1, 1'b1);
        `CHECK(n, 15 * P)
        `CHECK(nmi, 1'b0)
        @(posedge mclk);
        `CHECK(wdt_reset, 1'b0)
        dbg <= 1'b1;
        rchk(A_CNT, 32'h0000_00ff);
    endtask

    // the count below zero reads as 0x1ff with the negative flag
    task automatic t_negative();
        wr(A_CNT, 32'h0000_0001);
        dbg <= 1'b0;
        wait_for(1'b0, 1'b1);
        wait_for(1'b0, 1'b0);
        dbg <= 1'b1;
        rchk(A_CNT, 32'h0000_01ff);
    endtask

    // software freeze holds the count in mode zero
    task automatic t_freeze();
        wr(A_FSET, 32'h0000_0001);
        rchk(A_FSET, 32'h0000_0001);
        wr(A_CNT, 32'h0000_0005);
        dbg <= 1'b0;
        repeat (3 * P) @(posedge mclk);
        rchk(A_CNT, 32'h0000_0005);
        wr(A_FCLR, 32'h0000_0001);
        rchk(A_FCLR, 32'h0000_0000);
        repeat (2 * P) @(posedge mclk);
        bus(A_CNT, 1'b0, 32'h0000_0000);
        `CHECK((rd === 32'h0000_0003) || (rd === 32'h0000_0004), 1'b1)
        dbg <= 1'b1;
    endtask

    // mode one: set only, freeze ignored, reset at zero without nmi
    task automatic t_mode_one();
        wr(A_CTL, 32'h0000_0001);
        rchk(A_CTL, 32'h0000_0001);
        wr(A_CTL, 32'h0000_0000);
        rchk(A_CTL, 32'h0000_0001);
        wr(A_FSET, 32'h0000_0001);
        wr(A_CNT, 32'h0000_0003);
        dbg <= 1'b0;
        wait_for(1'b1, 1'b1);
        `CHECK((n > 2 * P) && (n <= 3 * P + 3), 1'b1)
        `CHECK(nmi, 1'b0)
        dbg <= 1'b1;
        rchk(A_CTL, 32'h0000_0000);
        rchk(A_FSET, 32'h0000_0000);
        rchk(A_CNT, 32'h0000_00ff);
    endtask

    // software reset clears mode, freeze and reloads the count
    task automatic t_sw_reset();
        wr(A_CTL, 32'h0000_0001);
        wr(A_FSET, 32'h0000_0001);
        wr(A_CNT, 32'h0000_0022);
        sw_rst <= 1'b1;
        @(posedge mclk);
        sw_rst <= 1'b0;
        @(posedge mclk);
        rchk(A_CTL, 32'h0000_0000);
        rchk(A_FSET, 32'h0000_0000);
        rchk(A_CNT, 32'h0000_00ff);
    endtask

    // ------------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // cut a hang short well beyond the few hundred cycles expected
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        end_of_test();
    end

    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_nmi_reset();
        t_negative();
        t_freeze();
        t_mode_one();
        t_sw_reset();
        end_of_test();
    end
endmodule
